//--- core/ulpfm_mux.sv
// Our own choice: the strobed register port.
`timescale 1ns/100ps

// Notes on behaviour
// - Port-one bit 4: sixth pin carries UART transmit
// - Port-one bit 0: fifth pin feeds UART receive while port-two bit 16 is clear
// - Port-two bit 20 clear: LIN transmit from internal pad unless bit 0 is set
// - Port-two bit 20 set: UART transmit drives LIN unless bit 0 is set
// - Port-two bit 16 clear: LIN receive off, diagnostics
// - Port-two bit 16 set: LIN receive to sync, UART
// - Port-two bit 4: eighth pin outputs LIN receive
// - Port-two bit 0: seventh pin drives LIN transmit
module ulpfm_mux (
  input  wire logic                     REF_CLK,
  input  wire logic                     RSTN,
  input  wire logic                     CE,
  input  wire ulpfm_pkg::ulpfm_bus_req_t BUS_REQ,
  output logic [31:0]                   BUS_RDATA,
  input  wire logic [3:0]               PIN_IN,
  output ulpfm_pkg::ulpfm_pad_t         PIN_DRIVE,
  input  wire ulpfm_pkg::ulpfm_pad_t    GPIO_DRIVE,
  output logic [3:0]                    GPIO_IN,
  input  wire logic                     UART_TXD,
  output logic                          UART_RXD,
  input  wire logic                     TX_PAD_DATA,
  input  wire logic                     HV_DIAG_IN,
  output logic                          RX_PAD_DATA,
  input  wire logic                     LIN_RXD,
  output logic                          LIN_TXD,
  output logic                          LIN_SYNC_RXD,
  output logic [1:0]                    LIN_MODE
);

  import ulpfm_pkg::*;

  // Reset release, two flip-flops
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Register and output state
  logic [31:0]         p1_q;
  logic [31:0]         p1_d;
  logic [31:0]         p2_q;
  logic [31:0]         p2_d;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;
  ulpfm_pad_t          pads_q;
  ulpfm_pad_t          pads_d;
  logic [NUM_PINS-1:0] gpio_in_q;
  logic [NUM_PINS-1:0] gpio_in_d;
  logic                uart_rxd_q;
  logic                uart_rxd_d;
  logic                lin_txd_q;
  logic                lin_txd_d;
  logic                lin_sync_q;
  logic                lin_sync_d;
  logic                rx_pad_q;
  logic                rx_pad_d;
  logic [1:0]          lin_mode_q;
  logic [1:0]          lin_mode_d;

  // Per-pin alternate function selects and drives
  logic [NUM_PINS-1:0] alt_sel;
  logic [NUM_PINS-1:0] alt_out;
  logic [NUM_PINS-1:0] alt_oe;
  logic [NUM_PINS-1:0] mux_out;
  logic [NUM_PINS-1:0] mux_oe;

  logic lin_rx_en;
  logic lin_tx_uart;
  logic standalone_tx;

  assign lin_rx_en     = p2_q[BIT_P2_LIN_RX_EN];
  assign lin_tx_uart   = p2_q[BIT_P2_LIN_TX_UART];
  assign standalone_tx = p2_q[BIT_P2_SEVENTH_LIN];

  always_comb begin
    alt_sel = '0;
    alt_out = '0;
    alt_oe  = '0;
    // Fifth pin becomes an input for UART receive
    alt_sel[PIN_FIFTH]   = p1_q[BIT_P1_FIFTH_RXD];
    // Sixth pin drives UART transmit
    alt_sel[PIN_SIXTH]   = p1_q[BIT_P1_SIXTH_TXD];
    alt_out[PIN_SIXTH]   = UART_TXD;
    alt_oe[PIN_SIXTH]    = 1'b1;
    // Seventh pin becomes an input toward the LIN transmitter
    alt_sel[PIN_SEVENTH] = standalone_tx;
    // Eighth pin drives the LIN receive data out
    alt_sel[PIN_EIGHTH]  = p2_q[BIT_P2_EIGHTH_LIN];
    alt_out[PIN_EIGHTH]  = LIN_RXD;
    alt_oe[PIN_EIGHTH]   = 1'b1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pad
      ulpfm_padsel u_padsel (
        .sel      (alt_sel[gi]),
        .alt_out  (alt_out[gi]),
        .alt_oe   (alt_oe[gi]),
        .gpio_out (GPIO_DRIVE.out[gi]),
        .gpio_oe  (GPIO_DRIVE.oe[gi]),
        .pad_out  (mux_out[gi]),
        .pad_oe   (mux_oe[gi])
      );
    end
  endgenerate

  always_comb begin
    p1_d    = p1_q;
    p2_d    = p2_q;
    rdata_d = DATA_ZERO;

    // Only select bits are stored, so reserved writes have no effect
    if (BUS_REQ.wr) begin
      case (BUS_REQ.addr)
        ADDR_PORT_ONE_FUNC: begin
          p1_d = BUS_REQ.wdata & MASK_PORT_ONE_FUNC;
        end
        ADDR_PORT_TWO_FUNC: begin
          p2_d = BUS_REQ.wdata & MASK_PORT_TWO_FUNC;
        end
        default: begin
          p1_d = p1_q;
        end
      endcase
    end

    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        ADDR_PORT_ONE_FUNC: begin
          rdata_d = p1_q & MASK_PORT_ONE_FUNC;
        end
        ADDR_PORT_TWO_FUNC: begin
          rdata_d = p2_q & MASK_PORT_TWO_FUNC;
        end
        default: begin
          rdata_d = DATA_ZERO;
        end
      endcase
    end

    pads_d.out = mux_out;
    pads_d.oe  = mux_oe;
    gpio_in_d  = PIN_IN;

    // LIN transmit source; the standalone pin path takes precedence
    if (standalone_tx) begin
      lin_txd_d = PIN_IN[PIN_SEVENTH];
    end else if (lin_tx_uart) begin
      lin_txd_d = UART_TXD;
    end else begin
      lin_txd_d = TX_PAD_DATA;
    end

    // LIN receive path; when disabled, sync idles and the pad data takes the diagnostic input
    if (lin_rx_en) begin
      lin_sync_d = LIN_RXD;
      rx_pad_d   = LIN_RXD;
    end else begin
      lin_sync_d = LINE_IDLE;
      rx_pad_d   = HV_DIAG_IN;
    end

    // UART receive: LIN data when enabled, else the fifth pin if selected, else idle
    if (lin_rx_en) begin
      uart_rxd_d = LIN_RXD;
    end else if (p1_q[BIT_P1_FIFTH_RXD]) begin
      uart_rxd_d = PIN_IN[PIN_FIFTH];
    end else begin
      uart_rxd_d = LINE_IDLE;
    end

    lin_mode_d = {lin_tx_uart, lin_rx_en};
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      p1_q       <= RST_PORT_ONE_FUNC;
      p2_q       <= RST_PORT_TWO_FUNC;
      rdata_q    <= DATA_ZERO;
      pads_q     <= '0;
      gpio_in_q  <= '0;
      uart_rxd_q <= LINE_IDLE;
      lin_txd_q  <= LINE_IDLE;
      lin_sync_q <= LINE_IDLE;
      rx_pad_q   <= 1'b0;
      lin_mode_q <= '0;
    end else if (CE) begin
      p1_q       <= p1_d;
      p2_q       <= p2_d;
      rdata_q    <= rdata_d;
      pads_q     <= pads_d;
      gpio_in_q  <= gpio_in_d;
      uart_rxd_q <= uart_rxd_d;
      lin_txd_q  <= lin_txd_d;
      lin_sync_q <= lin_sync_d;
      rx_pad_q   <= rx_pad_d;
      lin_mode_q <= lin_mode_d;
    end
  end

  assign BUS_RDATA    = rdata_q;
  assign PIN_DRIVE    = pads_q;
  assign GPIO_IN      = gpio_in_q;
  assign UART_RXD     = uart_rxd_q;
  assign LIN_TXD      = lin_txd_q;
  assign LIN_SYNC_RXD = lin_sync_q;
  assign RX_PAD_DATA  = rx_pad_q;
  assign LIN_MODE     = lin_mode_q;

endmodule

//--- core/ulpfm_pkg.sv
package ulpfm_pkg;

  // Register map, byte addresses on the 32-bit register port
  localparam logic [31:0] ADDR_PORT_ONE_FUNC = 32'hFFFF0D04;
  localparam logic [31:0] ADDR_PORT_TWO_FUNC = 32'hFFFF0D08;

  localparam logic [31:0] RST_PORT_ONE_FUNC = 32'h00000000;
  localparam logic [31:0] RST_PORT_TWO_FUNC = 32'h00000000;

  // Implemented select bits; every other position reads zero
  localparam logic [31:0] MASK_PORT_ONE_FUNC = 32'h00000011;
  localparam logic [31:0] MASK_PORT_TWO_FUNC = 32'h00110011;

  // Field positions, port-one function select
  localparam int unsigned BIT_P1_FIFTH_RXD = 0;
  localparam int unsigned BIT_P1_SIXTH_TXD = 4;

  // Field positions, port-two function select
  localparam int unsigned BIT_P2_SEVENTH_LIN = 0;
  localparam int unsigned BIT_P2_EIGHTH_LIN  = 4;
  localparam int unsigned BIT_P2_LIN_RX_EN   = 16;
  localparam int unsigned BIT_P2_LIN_TX_UART = 20;

  // Pad slots in the pin vectors
  localparam int unsigned NUM_PINS      = 4;
  localparam int unsigned PIN_FIFTH     = 0;
  localparam int unsigned PIN_SIXTH     = 1;
  localparam int unsigned PIN_SEVENTH   = 2;
  localparam int unsigned PIN_EIGHTH    = 3;

  // Recessive level of a serial line that nobody drives
  localparam logic LINE_IDLE = 1'b1;

  localparam logic [31:0] DATA_ZERO = 32'h00000000;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ulpfm_bus_req_t;

  // Output value and enable, one bit per pin slot
  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
  } ulpfm_pad_t;

endpackage

//--- core/ulpfm_padsel.sv
`timescale 1ns/100ps

// Chooses between the GPIO drive and the alternate function of one pad
module ulpfm_padsel (
  input  wire logic sel,
  input  wire logic alt_out,
  input  wire logic alt_oe,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  output logic      pad_out,
  output logic      pad_oe
);

  always_comb begin
    if (sel) begin
      pad_out = alt_out;
      pad_oe  = alt_oe;
    end else begin
      pad_out = gpio_out;
      pad_oe  = gpio_oe;
    end
  end

endmodule

//--- sim/ulpfm_far.sv
`timescale 1ns/100ps

// LIN bus echo with a second node pulling dominant, and a UART transmit
module ulpfm_far (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic lin_txd,
  output logic      lin_rxd,
  output logic      uart_txd
);
  logic [4:0] cnt_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q    <= 5'h00;
      lin_rxd  <= 1'b1;
      uart_txd <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 5'h03;
      lin_rxd  <= lin_txd & ~&cnt_q[1:0];
      uart_txd <= cnt_q[2];
    end
  end
endmodule

//--- sim/ulpfm_mux_properties.sv
`timescale 1ns/100ps

module ulpfm_mux_properties (
  input wire logic                      REF_CLK,
  input wire logic                      RSTN,
  input wire logic                      CE,
  input wire ulpfm_pkg::ulpfm_bus_req_t BUS_REQ,
  input wire logic [31:0]               BUS_RDATA,
  input wire logic [3:0]                PIN_IN,
  input wire ulpfm_pkg::ulpfm_pad_t     PIN_DRIVE,
  input wire ulpfm_pkg::ulpfm_pad_t     GPIO_DRIVE,
  input wire logic [3:0]                GPIO_IN,
  input wire logic                      UART_TXD,
  input wire logic                      UART_RXD,
  input wire logic                      TX_PAD_DATA,
  input wire logic                      HV_DIAG_IN,
  input wire logic                      RX_PAD_DATA,
  input wire logic                      LIN_RXD,
  input wire logic                      LIN_TXD,
  input wire logic                      LIN_SYNC_RXD,
  input wire logic [1:0]                LIN_MODE
);
  import ulpfm_pkg::*;
  logic [1:0]  rcnt_q;
  logic [5:0]  sh_q;
  logic [31:0] wd;
  logic [31:0] exp_rd;
  logic        wr1;
  logic        wr2;

  assign wd  = BUS_REQ.wdata;
  assign wr1 = CE && BUS_REQ.wr && BUS_REQ.addr == ADDR_PORT_ONE_FUNC;
  assign wr2 = CE && BUS_REQ.wr && BUS_REQ.addr == ADDR_PORT_TWO_FUNC;
  assign exp_rd = BUS_REQ.addr == ADDR_PORT_ONE_FUNC ?
    {27'h0, sh_q[1], 3'h0, sh_q[0]} : BUS_REQ.addr == ADDR_PORT_TWO_FUNC ?
    {11'h0, sh_q[5], 3'h0, sh_q[4], 11'h0, sh_q[3], 3'h0, sh_q[2]} : 32'h0;

  // Shadow {p2b20,p2b16,p2b4,p2b0,p1b4,p1b0}; checks wait out reset sync
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rcnt_q <= 2'h0;
      sh_q   <= 6'h00;
    end else begin
      rcnt_q <= rcnt_q == 2'h3 ? rcnt_q : rcnt_q + 2'h1;
      sh_q   <= {wr2 ? {wd[20], wd[16], wd[4], wd[0]} : sh_q[5:2],
                 wr1 ? {wd[4], wd[0]} : sh_q[1:0]};
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN || rcnt_q != 2'h3);

  sixth_txd_a: assert property ($past(CE) && $past(sh_q[1]) |->
    PIN_DRIVE.out[1] == $past(UART_TXD) && PIN_DRIVE.oe[1]) else $error("p6");
  fifth_rxd_a: assert property ($past(CE) && $past(sh_q[0]) &&
    !$past(sh_q[4]) |-> UART_RXD == $past(PIN_IN[0]) && !PIN_DRIVE.oe[0])
    else $error("p5");
  lin_tx_a: assert property ($past(CE) && !$past(sh_q[2]) |->
    LIN_TXD == ($past(sh_q[5]) ? $past(UART_TXD) : $past(TX_PAD_DATA)))
    else $error("ltx");
  rx_off_a: assert property ($past(CE) && !$past(sh_q[4]) |->
    LIN_SYNC_RXD && RX_PAD_DATA == $past(HV_DIAG_IN)) else $error("rxoff");
  rx_on_a: assert property ($past(CE) && $past(sh_q[4]) |->
    LIN_SYNC_RXD == $past(LIN_RXD) && UART_RXD == $past(LIN_RXD))
    else $error("rxon");
  eighth_pin_a: assert property ($past(CE) && $past(sh_q[3]) |->
    PIN_DRIVE.out[3] == $past(LIN_RXD) && PIN_DRIVE.oe[3]) else $error("p8");
  seventh_pin_a: assert property ($past(CE) && $past(sh_q[2]) |->
    LIN_TXD == $past(PIN_IN[2]) && !PIN_DRIVE.oe[2]) else $error("p7");
  read_back_a: assert property ($past(CE) && $past(BUS_REQ.rd) |->
    BUS_RDATA == $past(exp_rd)) else $error("rd");
endmodule

bind ulpfm_mux ulpfm_mux_properties u_props (.*);

//--- sim/ulpfm_mux_test.sv
`timescale 1ns/100ps

module ulpfm_mux_test;
  import ulpfm_pkg::*;
  logic           REF_CLK = 1'b0;
  logic           RSTN;
  logic           CE = 1'b1;
  ulpfm_bus_req_t BUS_REQ = '0;
  ulpfm_pad_t     GPIO_DRIVE = '0;
  ulpfm_pad_t     PIN_DRIVE;
  logic [31:0]    BUS_RDATA;
  logic [31:0]    e_rd;
  logic [31:0]    a;
  logic [3:0]     PIN_IN = 4'h0;
  logic [3:0]     GPIO_IN;
  logic [7:0]     e_pad;
  logic [9:0]     e_rest;
  logic [1:0]     LIN_MODE;
  logic           UART_TXD, LIN_RXD, TX_PAD_DATA = 1'b0, HV_DIAG_IN = 1'b0;
  logic           UART_RXD, RX_PAD_DATA, LIN_TXD, LIN_SYNC_RXD;
  bit             run = 1'b0;
  bit             armed = 1'b0;
  int             error_cnt = 0, n_checks = 0, cyc = 0, p1 = 0, p2 = 0;

  ulpfm_mux u_dut (.*);
  ulpfm_far u_far (.ref_clk(REF_CLK), .rstn(RSTN), .lin_txd(LIN_TXD),
    .lin_rxd(LIN_RXD), .uart_txd(UART_TXD));

  always #2 REF_CLK = ~REF_CLK;

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [49:0] got, input logic [49:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input logic [31:0] ad, input logic [31:0] d,
                      input bit w, input bit r);
    @(posedge REF_CLK);
    BUS_REQ     <= '{ad, d, w, r};
    CE          <= ($urandom % 8) != 0;
    GPIO_DRIVE  <= ulpfm_pad_t'($urandom);
    PIN_IN      <= 4'($urandom);
    TX_PAD_DATA <= 1'($urandom);
    HV_DIAG_IN  <= 1'($urandom);
  endtask

  // Outputs seen at an edge are the ones launched at the edge before
  always @(posedge REF_CLK) begin
    if (armed) begin
      chk(BUS_RDATA, e_rd);
      chk(PIN_DRIVE, e_pad);
      chk(GPIO_IN, e_rest[9:6]);
      chk({LIN_TXD, UART_RXD}, e_rest[5:4]);
      chk({LIN_SYNC_RXD, RX_PAD_DATA, LIN_MODE}, e_rest[3:0]);
    end
    if (run && CE) begin
      e_rd = 32'h0;
      if (BUS_REQ.rd && BUS_REQ.addr == ADDR_PORT_ONE_FUNC) e_rd = p1;
      if (BUS_REQ.rd && BUS_REQ.addr == ADDR_PORT_TWO_FUNC) e_rd = p2;
      e_pad = GPIO_DRIVE;
      if (p1[0]) {e_pad[4], e_pad[0]} = 2'b00;
      if (p1[4]) {e_pad[5], e_pad[1]} = {UART_TXD, 1'b1};
      if (p2[0]) {e_pad[6], e_pad[2]} = 2'b00;
      if (p2[4]) {e_pad[7], e_pad[3]} = {LIN_RXD, 1'b1};
      e_rest = {PIN_IN, p2[0] ? PIN_IN[2] : p2[20] ? UART_TXD : TX_PAD_DATA,
        p2[16] ? LIN_RXD : p1[0] ? PIN_IN[0] : 1'b1, p2[16] ? LIN_RXD : 1'b1,
        p2[16] ? LIN_RXD : HV_DIAG_IN, p2[20], p2[16]};
      if (BUS_REQ.wr && BUS_REQ.addr == ADDR_PORT_ONE_FUNC) p1 = BUS_REQ.wdata;
      if (BUS_REQ.wr && BUS_REQ.addr == ADDR_PORT_TWO_FUNC) p2 = BUS_REQ.wdata;
      armed = 1'b1;
    end
    cyc++;
    if (cyc > 6000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    RSTN = 1'b0;
    void'($urandom(32'hB489A875));
    repeat (6) @(posedge REF_CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    run <= 1'b1;
    for (int i = 0; i < 400; i++) begin
      a = $urandom % 2 ? ADDR_PORT_TWO_FUNC : ADDR_PORT_ONE_FUNC;
      step(a, $urandom & (a[3] ? 32'h00110011 : 32'h00000011), 1, 0);
      step(a, 32'h0, 0, 1);
      step(32'hFFFF0D0C, $urandom, 1, 0);
      step(32'hFFFF0D0C, 32'h0, 0, 1);
      repeat ($urandom % 3) step(32'h0, 32'h0, 0, 0);
    end
    // Let the last request's result be compared before the report
    repeat (2) step(32'h0, 32'h0, 0, 0);
    @(negedge REF_CLK);
    give_verdict();
  end
endmodule
